// [dhq_pkg.sv]
// Constants shared by the diagnostic history queue
package dhq_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned TICK_MS     = 1;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam logic [2:0]  PERSIST_MS  = 3'h5;
  localparam logic [7:0]  SURV_DEF_MS = 8'h50;
  // ----------------------------------------------------------------
  // Object indices and subindices
  // ----------------------------------------------------------------
  localparam logic [15:0] OBJ_HIST    = 16'h10f3;
  localparam logic [15:0] OBJ_DSTAT   = 16'hf100;
  localparam logic [15:0] OBJ_CFG     = 16'h2000;
  localparam logic [7:0]  OBJ_DIAG_HI = 8'ha0;
  localparam logic [7:0]  SUB_COUNT   = 8'h00;
  localparam logic [7:0]  SUB_CAP     = 8'h01;
  localparam logic [7:0]  SUB_NEWEST  = 8'h02;
  localparam logic [7:0]  SUB_ACK     = 8'h03;
  localparam logic [7:0]  SUB_NEW     = 8'h04;
  localparam logic [7:0]  SUB_FLAGS   = 8'h05;
  localparam logic [7:0]  SUB_BUF0    = 8'h06;
  localparam logic [7:0]  SUB_STATE   = 8'h01;
  localparam logic [7:0]  SUB_LOST    = 8'h02;
  localparam logic [7:0]  SUB_AUXEN   = 8'h01;
  localparam logic [7:0]  SUB_SURV    = 8'h02;
  // ----------------------------------------------------------------
  // Control flag bits
  // ----------------------------------------------------------------
  localparam int unsigned FLG_EMCY    = 0;
  localparam int unsigned FLG_NO_INFO = 1;
  localparam int unsigned FLG_NO_WARN = 2;
  localparam int unsigned FLG_NO_ERR  = 3;
  localparam int unsigned FLG_ACKMODE = 4;
  localparam int unsigned FLG_W       = 5;
  // ----------------------------------------------------------------
  // Abort codes
  // ----------------------------------------------------------------
  localparam logic [31:0] ABT_RANGE   = 32'h06090030;
  localparam logic [31:0] ABT_HIGH    = 32'h06090031;
  localparam logic [31:0] ABT_LOW     = 32'h06090032;
  localparam logic [31:0] ABT_RO      = 32'h06010002;
  localparam logic [31:0] ABT_NO_OBJ  = 32'h06020000;
  localparam logic [31:0] ABT_NO_SUB  = 32'h06090011;
  // ----------------------------------------------------------------
  // Message word: class in [15:14], source in [7:0]
  // ----------------------------------------------------------------
  localparam logic [1:0]  CLS_INFO    = 2'h1;
  localparam logic [1:0]  CLS_WARN    = 2'h2;
  localparam logic [1:0]  CLS_ERR     = 2'h3;
  localparam logic [7:0]  SRC_SUP     = 8'h01;
  localparam logic [7:0]  SRC_AUX     = 8'h02;
  localparam logic [7:0]  SRC_OUT     = 8'h10;
  localparam logic [7:0]  SRC_LINE    = 8'h20;
endpackage

// [dhq_queue.sv]
// Diagnostic event collection, output error filter and message history
`timescale 1ns/1ps
// Operation
// - Output switch-on blanks channel errors for programmable 0-255 ms, default 80.
// - Switched-on channel error must persist about 5 ms before reporting.
// - Supply voltage error raises a message, touches no output.
// - Auxiliary supply messages are off after reset until configured on.
// - Port line fault (removal, wrong device, short) raises a message.
// - Up to 64 messages from entry 6 in order; capacity field read-only.
// - Newest-entry field holds entry 6..69 of the latest message.
// - Overwrite mode: overwriting unacknowledged entries zeroes acknowledged field.
// - Overwrite mode: writing 0 discards all and clears fields, new flag and flag bit 5; flag bits 0..4 keep their value.
// - Writing 1..5 to acknowledged field aborts with too-low code.
// - Writing past last entry to acknowledged field aborts with too-high code.
// - Writing an empty entry to acknowledged field aborts with range code.
// - Valid 6..69 write acknowledges that entry and all older, unchecked.
// - Acknowledge mode: writing 0 deletes acknowledged; reading 0 means none.
// - New flag: newest unread (overwrite) or newest differs from acknowledged.
// - Flag bit 0 sends every new message as emergency message.
// - Flag bits 1..3 stop storing info, warning, error messages; default 0.
// - Flag bit 4 selects overwrite or acknowledge history mode.
// - Flag bit 5 read-only: overrun or discard indication.
// - Full buffer wraps to entry 6 keeping the latest messages; acknowledge mode drops new ones while none is acknowledged.
// - Per port an 8-bit state code is reported.
// - Per port an 8-bit lost telegram counter, cleared at start-up.
module dhq_queue
  import dhq_pkg::*;
#(
  parameter int unsigned NP     = 8,        // Ports
  parameter int unsigned CAP    = 64,       // History entries
  parameter int unsigned MS_CYC = TICK_CYC  // Clock cycles per ms
) (
  input  wire logic              mclk,            // Clock, 250 MHz
  input  wire logic              rst_n,           // Async reset, active low
  input  wire logic              ce,              // Clock enable
  input  wire logic              sdo_req,         // Access request pulse
  input  wire logic              sdo_wr,          // 1 write, 0 read
  input  wire logic [15:0]       sdo_index,       // Object index
  input  wire logic [7:0]        sdo_sub,         // Subindex
  input  wire logic [15:0]       sdo_wdata,       // Write data
  output logic                   sdo_done,        // Answer pulse
  output logic [15:0]            sdo_rdata,       // Read data
  output logic                   sdo_abort,       // Access refused
  output logic [31:0]            sdo_abort_code,  // Refusal reason
  input  wire logic              sup_fault_pin,   // System supply out of range
  input  wire logic              aux_fault_pin,   // Auxiliary supply out of range
  input  wire logic [NP-1:0]     out_cmd,         // Commanded output states
  input  wire logic [NP-1:0]     out_act_pin,     // Actual output levels
  input  wire logic [NP-1:0]     line_fault_pin,  // Port line faults
  input  wire logic [NP*8-1:0]   port_state,      // Port state codes
  input  wire logic [NP-1:0]     lost_tel,        // Lost telegram pulses
  input  wire logic [NP-1:0]     port_startup,    // Port start-up pulses
  output logic                   emcy_valid,      // Emergency message pulse
  output logic [15:0]            emcy_msg,        // Emergency message word
  output logic                   hist_new         // New messages flag
);
  localparam int unsigned AW = $clog2(CAP);
  localparam int unsigned CW = AW + 1;
  localparam int unsigned NS = 2 + 2 * NP;
  localparam int unsigned TW = $clog2(MS_CYC + 1);
  localparam logic [7:0]  LAST_SUB = 8'(CAP) + SUB_BUF0 - 8'h01;

  if (CAP < 2 || CAP > 64 || (CAP & (CAP - 1)) != 0) begin : g_bad_cap
    $error("CAP must be a power of two from 2 to 64");
  end
  if (NP < 1 || NP > 16 || MS_CYC < 2) begin : g_bad_np
    $error("NP must be 1 to 16 and MS_CYC at least 2");
  end

  typedef struct packed {
    logic                     sup_m, sup_s, aux_m, aux_s;
    logic [NP-1:0]            act_m, act_s, lf_m, lf_s;
    logic [TW-1:0]            tick_cnt;
    logic                     tick;
    logic [NP-1:0]            cmd_q, ofault;
    logic [NP-1:0][7:0]       blank;
    logic [NP-1:0][2:0]       persist;
    logic [NP-1:0][7:0]       lost;
    logic [NS-1:0]            cond_q, pend_on, pend_off;
    logic [CAP-1:0][15:0]     mem;
    logic [AW-1:0]            wr;
    logic [CW-1:0]            cnt, ackd;
    logic [7:0]               newest, ack, surv;
    logic                     new_ow, ovr, auxen;
    logic [FLG_W-1:0]         flags;
    logic                     sdo_done, sdo_abort, emcy_valid, hist_new;
    logic [15:0]              sdo_rdata, emcy_msg;
    logic [31:0]              sdo_abort_code;
  } dhq_state_t;

  dhq_state_t st_r, st_nxt;

  logic [NS-1:0] cond;
  logic [NS-1:0] svc;
  logic          any_on, any_off, take, store, do_wr, hist_wr, diag_hit;
  logic [15:0]   msg;
  logic [AW-1:0] oldest, slot, off;
  logic [3:0]    port_n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [NS-1:0] first_one(input logic [NS-1:0] v);
    logic [NS-1:0] r;
    r = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] src_of(input logic [NS-1:0] oh);
    logic [7:0] r;
    r = SRC_SUP;
    for (int i = 1; i < NS; i++) begin
      if (oh[i]) begin
        if (i == 1) r = SRC_AUX;
        else if (i < NP + 2) r = SRC_OUT + 8'(i - 2);
        else r = SRC_LINE + 8'(i - 2 - NP);
      end
    end
    return r;
  endfunction

  function automatic logic is_buf(input logic [7:0] sub);
    return sub >= SUB_BUF0 && sub <= LAST_SUB;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    cond     = '0;
    svc      = '0;
    any_on   = 1'b0;
    any_off  = 1'b0;
    take     = 1'b0;
    store    = 1'b0;
    do_wr    = 1'b0;
    msg      = '0;
    oldest   = st_r.wr - AW'(st_r.cnt);
    slot     = AW'(sdo_wdata[7:0] - SUB_BUF0);
    off      = slot - oldest;
    port_n   = sdo_index[7:4];
    hist_wr  = sdo_req && sdo_wr && sdo_index == OBJ_HIST;
    diag_hit = sdo_index[15:8] == OBJ_DIAG_HI && sdo_index[3:0] == 4'h0 && 32'(port_n) < NP;

    // Pin synchronisers, second stage only is read
    st_nxt.sup_m = sup_fault_pin;
    st_nxt.sup_s = st_r.sup_m;
    st_nxt.aux_m = aux_fault_pin;
    st_nxt.aux_s = st_r.aux_m;
    st_nxt.act_m = out_act_pin;
    st_nxt.act_s = st_r.act_m;
    st_nxt.lf_m  = line_fault_pin;
    st_nxt.lf_s  = st_r.lf_m;

    // Millisecond tick
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt == TW'(MS_CYC - 1)) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick     = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
    end

    // Output error filter; tick granularity makes the persist time 4 to 5 ms
    st_nxt.cmd_q = out_cmd;
    for (int c = 0; c < NP; c++) begin
      if (out_cmd[c] && !st_r.cmd_q[c]) begin
        st_nxt.blank[c]   = st_r.surv;
        st_nxt.persist[c] = '0;
        st_nxt.ofault[c]  = 1'b0;
      end else if (!out_cmd[c]) begin
        st_nxt.blank[c]   = '0;
        st_nxt.persist[c] = '0;
        st_nxt.ofault[c]  = 1'b0;
      end else if (st_r.blank[c] != 8'h00) begin
        if (st_r.tick) begin
          st_nxt.blank[c] = st_r.blank[c] - 8'h01;
        end
      end else if (out_cmd[c] != st_r.act_s[c]) begin
        if (st_r.tick && st_r.persist[c] != PERSIST_MS) begin
          st_nxt.persist[c] = st_r.persist[c] + 3'h1;
        end
        if (st_r.persist[c] == PERSIST_MS) begin
          st_nxt.ofault[c] = 1'b1;
        end
      end else begin
        st_nxt.persist[c] = '0;
        st_nxt.ofault[c]  = 1'b0;
      end
    end

    // Lost telegram counters
    for (int p = 0; p < NP; p++) begin
      if (port_startup[p]) begin
        st_nxt.lost[p] = 8'h00;
      end else if (lost_tel[p]) begin
        st_nxt.lost[p] = st_r.lost[p] + 8'h01;
      end
    end

    // Event sources; supply faults only report, no output is gated by them
    cond[0] = st_r.sup_s;
    cond[1] = st_r.aux_s && st_r.auxen;
    cond[NP+1:2] = st_r.ofault;
    cond[NS-1:NP+2] = st_r.lf_s;
    st_nxt.cond_q = cond;

    // One message per cycle; held off while the history is being written
    any_on  = |st_r.pend_on;
    any_off = |st_r.pend_off;
    take    = (any_on || any_off) && !hist_wr;
    if (take && any_on) begin
      svc = first_one(st_r.pend_on);
      msg = {(svc[1] ? CLS_WARN : CLS_ERR), 6'h00, src_of(svc)};
      st_nxt.pend_on = st_r.pend_on & ~svc;
    end else if (take) begin
      svc = first_one(st_r.pend_off);
      msg = {CLS_INFO, 6'h00, src_of(svc)};
      st_nxt.pend_off = st_r.pend_off & ~svc;
    end
    // New edges win over the service clear
    st_nxt.pend_on  = st_nxt.pend_on | (cond & ~st_r.cond_q);
    st_nxt.pend_off = st_nxt.pend_off | (~cond & st_r.cond_q);

    st_nxt.emcy_valid = take && st_r.flags[FLG_EMCY];
    if (take) begin
      st_nxt.emcy_msg = msg;
    end
    store = take && !(msg[15:14] == CLS_INFO && st_r.flags[FLG_NO_INFO])
                 && !(msg[15:14] == CLS_WARN && st_r.flags[FLG_NO_WARN])
                 && !(msg[15:14] == CLS_ERR && st_r.flags[FLG_NO_ERR]);

    // Object access
    st_nxt.sdo_done = sdo_req;
    if (sdo_req) begin
      st_nxt.sdo_abort      = 1'b0;
      st_nxt.sdo_abort_code = '0;
      st_nxt.sdo_rdata      = '0;
      if (sdo_index == OBJ_HIST) begin
        if (sdo_wr && sdo_sub == SUB_ACK) begin
          if (sdo_wdata == 16'h0000) begin
            if (!st_r.flags[FLG_ACKMODE]) begin
              st_nxt.cnt    = '0;
              st_nxt.ackd   = '0;
              st_nxt.wr     = '0;
              st_nxt.newest = 8'h00;
              st_nxt.ack    = 8'h00;
              st_nxt.new_ow = 1'b0;
              st_nxt.ovr    = 1'b0;
            end else begin
              st_nxt.cnt  = st_r.cnt - st_r.ackd;
              st_nxt.ackd = '0;
              st_nxt.ack  = 8'h00;
              if (st_r.cnt == st_r.ackd) begin
                st_nxt.newest = 8'h00;
              end
            end
          end else if (sdo_wdata < 16'(SUB_BUF0)) begin
            st_nxt.sdo_abort      = 1'b1;
            st_nxt.sdo_abort_code = ABT_LOW;
          end else if (sdo_wdata > 16'(LAST_SUB)) begin
            st_nxt.sdo_abort      = 1'b1;
            st_nxt.sdo_abort_code = ABT_HIGH;
          end else if ({1'b0, off} >= st_r.cnt) begin
            st_nxt.sdo_abort      = 1'b1;
            st_nxt.sdo_abort_code = ABT_RANGE;
          end else begin
            st_nxt.ack  = sdo_wdata[7:0];
            st_nxt.ackd = {1'b0, off} + 1'b1;
          end
        end else if (sdo_wr && sdo_sub == SUB_FLAGS) begin
          st_nxt.flags = sdo_wdata[FLG_W-1:0];
        end else if (sdo_wr && (sdo_sub <= LAST_SUB)) begin
          st_nxt.sdo_abort      = 1'b1;
          st_nxt.sdo_abort_code = ABT_RO;
        end else if (sdo_sub == SUB_COUNT) begin
          st_nxt.sdo_rdata = {8'h00, LAST_SUB};
        end else if (sdo_sub == SUB_CAP) begin
          st_nxt.sdo_rdata = 16'(CAP);
        end else if (sdo_sub == SUB_NEWEST) begin
          st_nxt.sdo_rdata = {8'h00, st_r.newest};
        end else if (sdo_sub == SUB_ACK) begin
          st_nxt.sdo_rdata = {8'h00, st_r.ack};
        end else if (sdo_sub == SUB_NEW) begin
          st_nxt.sdo_rdata = {15'h0000, st_r.hist_new};
        end else if (sdo_sub == SUB_FLAGS) begin
          st_nxt.sdo_rdata = {10'h000, st_r.ovr, st_r.flags};
        end else if (is_buf(sdo_sub)) begin
          st_nxt.sdo_rdata = st_r.mem[AW'(sdo_sub - SUB_BUF0)];
          if (sdo_sub == st_r.newest) begin
            st_nxt.new_ow = 1'b0;
          end
        end else begin
          st_nxt.sdo_abort      = 1'b1;
          st_nxt.sdo_abort_code = ABT_NO_SUB;
        end
      end else if (sdo_index == OBJ_CFG && (sdo_sub == SUB_AUXEN || sdo_sub == SUB_SURV)) begin
        if (sdo_wr && sdo_sub == SUB_AUXEN) begin
          st_nxt.auxen = sdo_wdata[0];
        end else if (sdo_wr) begin
          st_nxt.surv = sdo_wdata[7:0];
        end else begin
          st_nxt.sdo_rdata = {8'h00, (sdo_sub == SUB_AUXEN) ? {7'h00, st_r.auxen} : st_r.surv};
        end
      end else if (diag_hit && (sdo_sub == SUB_STATE || sdo_sub == SUB_LOST)) begin
        if (sdo_wr) begin
          st_nxt.sdo_abort      = 1'b1;
          st_nxt.sdo_abort_code = ABT_RO;
        end else if (sdo_sub == SUB_STATE) begin
          st_nxt.sdo_rdata = {8'h00, port_state[port_n*8 +: 8]};
        end else begin
          st_nxt.sdo_rdata = {8'h00, st_r.lost[port_n]};
        end
      end else if (sdo_index == OBJ_DSTAT && sdo_sub != 8'h00 && 32'(sdo_sub) <= NP) begin
        if (sdo_wr) begin
          st_nxt.sdo_abort      = 1'b1;
          st_nxt.sdo_abort_code = ABT_RO;
        end else begin
          st_nxt.sdo_rdata = {8'h00, port_state[(sdo_sub - 8'h01)*8 +: 8]};
        end
      end else begin
        st_nxt.sdo_abort      = 1'b1;
        st_nxt.sdo_abort_code = ABT_NO_OBJ;
      end
    end

    // History store; never in the same cycle as a history write
    if (store) begin
      do_wr = 1'b1;
      if (st_r.cnt == CW'(CAP)) begin
        if (st_r.ackd != '0) begin
          st_nxt.ackd = st_r.ackd - 1'b1;
          if (st_r.ackd == CW'(1)) begin
            st_nxt.ack = 8'h00;
          end
        end else if (st_r.flags[FLG_ACKMODE]) begin
          do_wr      = 1'b0;
          st_nxt.ovr = 1'b1;
        end else begin
          st_nxt.ack = 8'h00;
          st_nxt.ovr = 1'b1;
        end
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
      if (do_wr) begin
        st_nxt.mem[st_r.wr] = msg;
        st_nxt.newest       = 8'(st_r.wr) + SUB_BUF0;
        st_nxt.wr           = st_r.wr + 1'b1;
        st_nxt.new_ow       = 1'b1;
      end
    end
    st_nxt.hist_new = st_nxt.flags[FLG_ACKMODE] ? (st_nxt.newest != st_nxt.ack)
                                                : st_nxt.new_ow;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.surv <= SURV_DEF_MS;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign sdo_done       = st_r.sdo_done;
  assign sdo_rdata      = st_r.sdo_rdata;
  assign sdo_abort      = st_r.sdo_abort;
  assign sdo_abort_code = st_r.sdo_abort_code;
  assign emcy_valid     = st_r.emcy_valid;
  assign emcy_msg       = st_r.emcy_msg;
  assign hist_new       = st_r.hist_new;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_ack_too_low: assert property (
    ce && hist_wr && sdo_sub == SUB_ACK && sdo_wdata != 16'h0 && sdo_wdata < 16'(SUB_BUF0)
    |=> sdo_done && sdo_abort && sdo_abort_code == ABT_LOW)
    else $error("ack write 1..5 not refused as too low");
  a_ack_too_high: assert property (
    ce && hist_wr && sdo_sub == SUB_ACK && sdo_wdata > 16'(LAST_SUB)
    |=> sdo_abort && sdo_abort_code == ABT_HIGH)
    else $error("ack write past last entry not refused as too high");
  a_clear_all_ow: assert property (
    ce && hist_wr && sdo_sub == SUB_ACK && sdo_wdata == 16'h0 && !st_r.flags[FLG_ACKMODE]
    |=> st_r.cnt == '0 && st_r.newest == 8'h00 && st_r.ack == 8'h00 && !st_r.ovr && !hist_new)
    else $error("overwrite mode clear did not empty history");
  a_blank_load: assert property (
    ce && out_cmd[0] && !st_r.cmd_q[0] |=> st_r.blank[0] == $past(st_r.surv) && !st_r.ofault[0])
    else $error("switch-on did not load the blanking window");
  a_fault_persist: assert property (
    $rose(st_r.ofault[0]) |-> st_r.persist[0] == PERSIST_MS && st_r.blank[0] == 8'h00)
    else $error("output fault raised before persist time");
  a_aux_gated: assert property (
    !st_r.auxen |-> ##1 !st_r.cond_q[1])
    else $error("aux supply event passed while disabled");
  a_newest_range: assert property (
    st_r.newest == 8'h00 || (st_r.newest >= SUB_BUF0 && st_r.newest <= LAST_SUB))
    else $error("newest entry outside buffer");
  a_count_bound: assert property (
    st_r.cnt <= CW'(CAP) && st_r.ackd <= st_r.cnt)
    else $error("history count out of bounds");
  a_emcy_flag: assert property (
    ce && $rose(emcy_valid) |-> $past(st_r.flags[FLG_EMCY]))
    else $error("emergency sent while disabled");
endmodule

// [dhq_master.sv]
// Fieldbus master model issuing object accesses
`timescale 1ns/1ps
module dhq_master (
  input  wire logic        mclk,      // Clock
  output logic             sdo_req,   // Request pulse
  output logic             sdo_wr,    // Write select
  output logic [15:0]      sdo_index, // Object index
  output logic [7:0]       sdo_sub,   // Subindex
  output logic [15:0]      sdo_wdata, // Write data
  input  wire logic        sdo_done,  // Answer pulse
  input  wire logic [15:0] sdo_rdata, // Read data
  input  wire logic        sdo_abort, // Refused
  input  wire logic [31:0] sdo_abort_code // Reason
);
  initial begin
    sdo_req   = 1'b0;
    sdo_wr    = 1'b0;
    sdo_index = 16'h0000;
    sdo_sub   = 8'h00;
    sdo_wdata = 16'h0000;
  end
  // One access at a time; qualifiers stand until the answer edge
  task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
                        input logic [15:0] d, output logic [15:0] r, output logic [31:0] c);
    int n;
    n = 0;
    @(posedge mclk);
    sdo_req   <= 1'b1;
    sdo_wr    <= w;
    sdo_index <= i;
    sdo_sub   <= s;
    sdo_wdata <= d;
    @(posedge mclk);
    sdo_req   <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (sdo_done !== 1'b1 && n < 8);
    r = sdo_rdata;
    c = (sdo_abort === 1'b1) ? sdo_abort_code : 32'h00000000;
    // A missing answer leaves unknowns, which no expected value matches
    if (sdo_done !== 1'b1) begin
      r = 'x;
      c = 'x;
    end
  endtask
endmodule

// [testbench.sv]
// Object access regression of the diagnostic history queue
`timescale 1ns/1ps
module testbench;
  import dhq_pkg::*;
  localparam int unsigned CAP = 4;
  logic        mclk, rst_n, sup, aux;
  logic [7:0]  cmd, act, line, lost, stup;
  logic [63:0] pst;
  wire         req, wr, done, ab, ev, hn;
  wire  [15:0] idx, wd, rdat, em;
  wire  [7:0]  sub;
  wire  [31:0] cd;
  int          n_fail, checks, n_em;
  dhq_queue #(.NP(8), .CAP(CAP), .MS_CYC(20)) dut (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
    .sdo_req(req), .sdo_wr(wr), .sdo_index(idx), .sdo_sub(sub), .sdo_wdata(wd),
    .sdo_done(done), .sdo_rdata(rdat), .sdo_abort(ab), .sdo_abort_code(cd),
    .sup_fault_pin(sup), .aux_fault_pin(aux), .out_cmd(cmd), .out_act_pin(act),
    .line_fault_pin(line), .port_state(pst), .lost_tel(lost), .port_startup(stup),
    .emcy_valid(ev), .emcy_msg(em), .hist_new(hn));
  dhq_master m (.mclk(mclk), .sdo_req(req), .sdo_wr(wr), .sdo_index(idx), .sdo_sub(sub),
    .sdo_wdata(wd), .sdo_done(done), .sdo_rdata(rdat), .sdo_abort(ab), .sdo_abort_code(cd));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (ev === 1'b1) n_em++;
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [15:0] e);
    logic [15:0] r;
    logic [31:0] c;
    m.access(1'b0, i, s, 16'h0000, r, c);
    chk16($sformatf("read %h:%h", i, s), e, r);
  endtask
  task automatic wrc(input logic [15:0] i, input logic [7:0] s, input logic [15:0] d,
                     input logic [31:0] e);
    logic [15:0] r;
    logic [31:0] c;
    m.access(1'b1, i, s, d, r, c);
    chk32($sformatf("abort %h:%h=%h", i, s, d), e, c);
  endtask
  // Sync, edge, take and store all fit well inside this
  task automatic settle();
    repeat (12) @(posedge mclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    report_and_stop();
  end
  initial begin
    {sup, aux, cmd, act, line, lost, stup} = '0;
    pst = 64'h0900000000080000;
    rst_n = 1'b0;
    n_fail = 0;
    checks = 0;
    n_em = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OBJ_HIST, SUB_CAP, 16'(CAP));
    rd(OBJ_HIST, SUB_FLAGS, 16'h0000);
    rd(OBJ_HIST, SUB_NEWEST, 16'h0000);
    $display("test reset values done");
    aux <= 1'b1;
    settle();
    rd(OBJ_HIST, SUB_NEWEST, 16'h0000);
    aux <= 1'b0;
    settle();
    wrc(OBJ_CFG, SUB_AUXEN, 16'h0001, 32'h0);
    aux <= 1'b1;
    settle();
    rd(OBJ_HIST, SUB_BUF0, 16'h8002);
    sup <= 1'b1;
    settle();
    rd(OBJ_HIST, SUB_NEWEST, 16'h0007);
    chk16("hist_new", 16'h0001, {15'h0, hn});
    rd(OBJ_HIST, 8'h07, 16'hc001);
    chk16("hist_new", 16'h0000, {15'h0, hn});
    chk16("emcy count", 16'h0000, n_em[15:0]);
    $display("test supply messages done");
    wrc(OBJ_HIST, SUB_ACK, 16'h0003, ABT_LOW);
    wrc(OBJ_HIST, SUB_ACK, 16'h000a, ABT_HIGH);
    wrc(OBJ_HIST, SUB_ACK, 16'h0008, ABT_RANGE);
    wrc(OBJ_HIST, SUB_ACK, 16'h0006, 32'h0);
    rd(OBJ_HIST, SUB_ACK, 16'h0006);
    wrc(OBJ_HIST, SUB_FLAGS, 16'hffc1, 32'h0);
    rd(OBJ_HIST, SUB_FLAGS, 16'h0001);
    line <= 8'h01;
    settle();
    rd(OBJ_HIST, SUB_BUF0 + 8'h2, 16'hc020);
    chk16("emcy msg", 16'hc020, em);
    chk16("emcy count", 16'h0001, n_em[15:0]);
    wrc(OBJ_HIST, SUB_FLAGS, 16'h0000, 32'h0);
    wrc(OBJ_HIST, SUB_ACK, 16'h0000, 32'h0);
    rd(OBJ_HIST, SUB_NEWEST, 16'h0000);
    rd(OBJ_HIST, SUB_ACK, 16'h0000);
    chk16("hist_new", 16'h0000, {15'h0, hn});
    $display("test acknowledge field done");
    // Five messages into four entries: the last lands on entry 6 again
    repeat (5) begin
      sup <= ~sup;
      settle();
    end
    rd(OBJ_HIST, SUB_NEWEST, 16'h0006);
    rd(OBJ_HIST, SUB_BUF0, 16'h4001);
    rd(OBJ_HIST, SUB_BUF0 + 8'h1, 16'hc001);
    rd(OBJ_HIST, SUB_FLAGS, 16'h0020);
    rd(OBJ_HIST, SUB_ACK, 16'h0000);
    $display("test wrap done");
    // 8 ms blanking plus 5 ms persist: no report before about 240 cycles
    wrc(OBJ_CFG, SUB_SURV, 16'h0008, 32'h0);
    cmd <= 8'h01;
    repeat (195) @(posedge mclk);
    rd(OBJ_HIST, SUB_NEWEST, 16'h0006);
    repeat (150) @(posedge mclk);
    rd(OBJ_HIST, SUB_BUF0 + 8'h1, 16'hc010);
    $display("test output filter done");
    rd(16'ha020, SUB_STATE, 16'h0008);
    rd(OBJ_DSTAT, 8'h08, 16'h0009);
    repeat (3) begin
      lost <= 8'h02;
      @(posedge mclk);
      lost <= 8'h00;
      @(posedge mclk);
    end
    rd(16'ha010, SUB_LOST, 16'h0003);
    stup <= 8'h02;
    @(posedge mclk);
    stup <= 8'h00;
    rd(16'ha010, SUB_LOST, 16'h0000);
    $display("test port objects done");
    wrc(OBJ_HIST, SUB_ACK, 16'h0000, 32'h0);
    wrc(OBJ_HIST, SUB_FLAGS, 16'h0012, 32'h0);
    // Five errors, infos dropped; the fifth finds no acknowledged slot
    repeat (9) begin
      sup <= ~sup;
      settle();
    end
    rd(OBJ_HIST, SUB_FLAGS, 16'h0032);
    rd(OBJ_HIST, SUB_NEWEST, 16'h0009);
    rd(OBJ_HIST, SUB_BUF0 + 8'h1, 16'hc001);
    wrc(OBJ_HIST, SUB_ACK, 16'h0007, 32'h0);
    chk16("hist_new", 16'h0001, {15'h0, hn});
    wrc(OBJ_HIST, SUB_ACK, 16'h0000, 32'h0);
    rd(OBJ_HIST, SUB_ACK, 16'h0000);
    wrc(OBJ_HIST, SUB_ACK, 16'h0006, ABT_RANGE);
    wrc(OBJ_HIST, SUB_ACK, 16'h0009, 32'h0);
    chk16("hist_new", 16'h0000, {15'h0, hn});
    $display("test acknowledge mode done");
    report_and_stop();
  end
endmodule
